// ---- hw/asrp_pkg.sv ----
// Purpose: Shared constants and types for the converter serial result port
// Assumes: 10 MHz system clock; link pins sampled by that clock
// Notes: Channel select field of the control word is a local layout
package asrp_pkg;
	localparam int SYS_CLK_HZ = 10_000_000;
	localparam int TEMP_CONV_US = 100;
	localparam int TEMP_CONV_CYC = TEMP_CONV_US * (SYS_CLK_HZ / 1_000_000);
	localparam int FRAME_BITS = 16;
	localparam int RES_BITS = 12;
	localparam int TAG_BITS = 4;
	localparam int NUM_VIN = 8;
	localparam logic [3:0] TEMP_TAG = 4'h8;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam int CH_SEL_LSB = 0;
	localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
	localparam logic [4:0] BIT_CNT_FULL = 5'h10;
	localparam logic [11:0] RES_RESET = 12'h000;

	typedef struct packed {
		logic [TAG_BITS-1:0] tag;
		logic [RES_BITS-1:0] result;
	} asrp_frame_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV_V = 3'b010,
		ST_CONV_T = 3'b100
	} asrp_state_e;
endpackage

// ---- hw/asrp_top.sv ----
// Purpose: Serial result port of an eight-channel 12-bit sampling converter
// Assumes: Host makes serial clock and chip select; serial link pins synchronised here
// Notes: Result of a conversion is read in the frame after the one that starts it
`timescale 1ns/1ps
module asrp_top
	import asrp_pkg::*;
#(
	parameter int SYNC_STAGES = 2
)
(
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// Serial link pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	output logic o_dout,
	output logic o_dout_oe_n,
	// Converter front end
	input wire logic [NUM_VIN*RES_BITS-1:0] i_vin_codes,
	input wire logic [RES_BITS-1:0] i_temp_code,
	output logic [2:0] o_mux_sel,
	output logic o_hold,
	// Status
	output logic o_temp_conv_pending,
	output logic [FRAME_BITS-1:0] o_ctrl_word
);

	logic [SYNC_STAGES-1:0] sclk_sync;
	logic [SYNC_STAGES-1:0] cs_sync;
	logic [SYNC_STAGES-1:0] din_sync;
	logic sclk_prev;
	logic cs_prev;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic cs_low;
	logic din_s;
	logic [4:0] bit_cnt;
	logic [FRAME_BITS-1:0] ctrl_shift;
	logic [FRAME_BITS-1:0] out_shift;
	logic [RES_BITS-1:0] held_code;
	logic [TAG_BITS-1:0] held_tag;
	asrp_frame_s last_frame;
	asrp_state_e state;
	logic [$clog2(TEMP_CONV_CYC+1)-1:0] temp_cnt;
	logic [TAG_BITS-1:0] sel_tag;

	// Pin synchronisers
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sclk_sync <= '0;
			cs_sync <= '1;
			din_sync <= '0;
			sclk_prev <= 1'b0;
			cs_prev <= 1'b1;
		end
		else if (i_clk_en)
		begin
			sclk_sync <= {sclk_sync[SYNC_STAGES-2:0], i_sclk};
			cs_sync <= {cs_sync[SYNC_STAGES-2:0], i_cs_n};
			din_sync <= {din_sync[SYNC_STAGES-2:0], i_din};
			sclk_prev <= sclk_sync[SYNC_STAGES-1];
			cs_prev <= cs_sync[SYNC_STAGES-1];
		end
	end

	assign cs_low = !cs_sync[SYNC_STAGES-1];
	assign din_s = din_sync[SYNC_STAGES-1];
	assign sclk_fall = sclk_prev && !sclk_sync[SYNC_STAGES-1] && cs_low;
	assign cs_fall = cs_prev && cs_low;
	assign cs_rise = !cs_prev && !cs_low;
	assign sel_tag = o_ctrl_word[CH_SEL_LSB +: TAG_BITS];

	// Frame bit counter
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			bit_cnt <= BIT_CNT_ZERO;
		else if (i_clk_en)
		begin
			if (cs_fall || cs_rise)
				bit_cnt <= BIT_CNT_ZERO;
			else if (sclk_fall && bit_cnt != BIT_CNT_FULL)
				bit_cnt <= bit_cnt + 5'h01;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ctrl_shift <= CTRL_RESET;
			o_ctrl_word <= CTRL_RESET;
		end
		else if (i_clk_en)
		begin
			if (sclk_fall && bit_cnt != BIT_CNT_FULL)
				ctrl_shift <= {ctrl_shift[FRAME_BITS-2:0], din_s};
			if (sclk_fall && bit_cnt == BIT_CNT_FULL - 5'h01)
				o_ctrl_word <= {ctrl_shift[FRAME_BITS-2:0], din_s};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			out_shift <= '0;
			o_dout <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (cs_fall)
			begin
				out_shift <= last_frame;
				o_dout <= last_frame[FRAME_BITS-1];
			end
			else if (sclk_fall && bit_cnt < BIT_CNT_FULL - 5'h01)
			begin
				out_shift <= {out_shift[FRAME_BITS-2:0], 1'b0};
				o_dout <= out_shift[FRAME_BITS-2];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_dout_oe_n <= 1'b1;
		else if (i_clk_en)
			o_dout_oe_n <= !cs_low;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_mux_sel <= 3'h0;
			held_code <= RES_RESET;
			held_tag <= 4'h0;
		end
		else if (i_clk_en)
		begin
			if (sel_tag < TEMP_TAG)
				o_mux_sel <= sel_tag[2:0];
			if (cs_fall && state == ST_IDLE)
			begin
				held_tag <= sel_tag;
				if (sel_tag < TEMP_TAG)
					held_code <= i_vin_codes[sel_tag[2:0]*RES_BITS +: RES_BITS];
				else
					held_code <= i_temp_code;
			end
		end
	end

	// Conversion sequencer
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state <= ST_IDLE;
			temp_cnt <= '0;
			o_hold <= 1'b0;
			o_temp_conv_pending <= 1'b0;
			last_frame <= '0;
		end
		else if (i_clk_en)
		begin
			case (state)
				ST_IDLE:
				begin
					if (cs_fall)
					begin
						o_hold <= 1'b1;
						if (sel_tag < TEMP_TAG)
							state <= ST_CONV_V;
						else
						begin
							state <= ST_CONV_T;
							o_temp_conv_pending <= 1'b1;
							temp_cnt <= '0;
						end
					end
				end
				ST_CONV_V:
				begin
					if (sclk_fall && bit_cnt == BIT_CNT_FULL - 5'h01)
					begin
						last_frame <= '{tag: held_tag, result: held_code};
						state <= ST_IDLE;
						o_hold <= 1'b0;
					end
					else if (cs_rise)
					begin
						state <= ST_IDLE;
						o_hold <= 1'b0;
					end
				end
				ST_CONV_T:
				begin
					if (temp_cnt == TEMP_CONV_CYC[$bits(temp_cnt)-1:0] - 1'b1)
					begin
						last_frame <= '{tag: held_tag, result: held_code};
						state <= ST_IDLE;
						o_hold <= 1'b0;
						o_temp_conv_pending <= 1'b0;
					end
					else
						temp_cnt <= temp_cnt + 1'b1;
				end
				default:
				begin
					state <= ST_IDLE;
					o_hold <= 1'b0;
					o_temp_conv_pending <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ---- tb/asrp_properties.sv ----
// Purpose: Link checks at the top ports
// Assumes: Pins seen 3 to 4 clocks late
// Notes: Bound to every top instance
`timescale 1ns/1ps
module asrp_properties
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Watched pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic o_dout,
	input wire logic o_dout_oe_n,
	input wire logic o_hold,
	input wire logic o_temp_conv_pending,
	input wire logic [15:0] o_ctrl_word
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	a_oe_off: assert property (i_cs_n [*6] |-> o_dout_oe_n) else $error("oe idle");
	a_oe_on: assert property ((!i_cs_n) [*6] |-> !o_dout_oe_n) else $error("oe off");
	a_bit_edge: assert property (($stable(i_sclk) && $stable(i_cs_n)) [*6] |=>
		$stable(o_dout)) else $error("dout moved");
	a_busy_start: assert property ($rose(o_temp_conv_pending) |-> $rose(o_hold))
		else $error("busy start");
	a_temp_time: assert property ($rose(o_temp_conv_pending) |=>
		o_temp_conv_pending [*8] ##[1:992] !o_temp_conv_pending) else $error("temp time");
	a_volt_time: assert property ($rose(o_hold) ##1 !o_temp_conv_pending |->
		##[0:150] !o_hold) else $error("volt time");
	a_hold_cs: assert property ($rose(o_hold) |-> !i_cs_n && $past(!i_cs_n, 2))
		else $error("hold cause");
	a_ctrl_frame: assert property ($changed(o_ctrl_word) |-> $past(!i_cs_n, 3))
		else $error("ctrl moved");
	c_temp: cover property ($rose(o_temp_conv_pending));
	c_volt: cover property ($fell(o_hold) && !o_temp_conv_pending);
	c_frame: cover property ($rose(o_dout_oe_n));
endmodule
bind asrp_top asrp_properties chk_u (.i_sys_clk, .i_resetn, .i_sclk, .i_cs_n, .o_dout,
	.o_dout_oe_n, .o_hold, .o_temp_conv_pending, .o_ctrl_word);

// ---- tb/asrp_host.sv ----
// Purpose: Host serial master model
// Assumes: Serial clock idles high, 8 clocks a period
// Notes: Pins move on the falling clock edge
`timescale 1ns/1ps
module asrp_host
(
	// System side
	input wire logic i_sys_clk,
	// Link pins
	input wire logic i_dout,
	input wire logic i_temp_conv_pending,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din
);
	initial
	begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic frame(input logic [15:0] ctl, input int nb, output logic [15:0] rd);
		rd = 16'h0000;
		for (int w = 0; w < 2000 && i_temp_conv_pending !== 1'b0; w++)
			wt(1);
		o_cs_n = 1'b0;
		wt(4);
		for (int i = 0; i < nb; i++)
		begin
			o_din = ctl[15 - i];
			wt(4);
			rd[15 - i] = i_dout;
			o_sclk = 1'b0;
			wt(4);
			o_sclk = 1'b1;
		end
		wt(4);
		o_cs_n = 1'b1;
		o_din = ~o_din;
		wt(8);
	endtask
endmodule

// ---- tb/asrp_top_tb.sv ----
// Purpose: Self-checking bench for the result port
// Assumes: 10 MHz clock, host model on the link
// Notes: Results come two frames after the control word that selects them
`timescale 1ns/1ps
module asrp_top_tb;
	import asrp_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic sclk, cs_n, din, dout, oe_n, hold, pend;
	logic [2:0] msel;
	logic [FRAME_BITS-1:0] ctrl, rd;
	logic [NUM_VIN*RES_BITS-1:0] vin;
	logic [RES_BITS-1:0] tcode = 12'hf9c;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	asrp_top dut_u (.i_sys_clk(clk), .i_resetn(resetn), .i_clk_en(1'b1), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe_n(oe_n), .i_vin_codes(vin),
		.i_temp_code(tcode), .o_mux_sel(msel), .o_hold(hold), .o_temp_conv_pending(pend),
		.o_ctrl_word(ctrl));
	asrp_host host_u (.i_sys_clk(clk), .i_dout(dout), .i_temp_conv_pending(pend),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
	always #50 clk = ~clk;
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic t_volt();
		int ch;
		for (int k = 0; k < 10; k++)
		begin
			host_u.frame(16'(k % 8), 16, rd);
			ch = (k < 2) ? 0 : k - 2;
			chk(rd, (k == 0) ? 16'h0000 : {4'(ch), vin[ch*12 +: 12]});
			chk(ctrl, 16'(k % 8));
			chk(16'(msel), 16'(k % 8));
			chk(16'(oe_n), 16'h0001);
		end
		$display("t_volt done");
	endtask
	task automatic t_temp();
		host_u.frame(16'h0008, 16, rd);
		host_u.frame(16'h0000, 16, rd);
		chk(16'(pend), 16'h0001);
		host_u.frame(16'h0003, 16, rd);
		chk(rd, {TEMP_TAG, tcode});
		$display("t_temp done");
	endtask
	task automatic t_abort();
		host_u.frame(16'h0005, 8, rd);
		chk(rd, {4'h0, vin[11:8], 8'h00});
		chk(ctrl, 16'h0003);
		host_u.frame(16'h0000, 16, rd);
		chk(rd, {4'h0, vin[11:0]});
		$display("t_abort done");
	endtask
	initial
	begin
		for (int k = 0; k < NUM_VIN; k++)
			vin[k*12 +: 12] = 12'ha50 + 12'(k * 17);
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		t_volt();
		t_temp();
		t_abort();
		finish_test();
	end
endmodule
